/* logic/sad_pkg.sv */
// Constants shared by the stereo audio input path
`default_nettype none
package sad_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CLK    = 8'h04;
  localparam logic [7:0] OFS_FRAC   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_LEFT   = 8'h10;
  localparam logic [7:0] OFS_RIGHT  = 8'h14;
  localparam logic [7:0] OFS_COEF   = 8'h40;
  localparam int         NUM_COEF   = 20;
  // Control field positions
  localparam int CTRL_DAC_EN  = 0;
  localparam int CTRL_PLL_EN  = 1;
  localparam int CTRL_REF48   = 2;
  localparam int CTRL_FMT_LO  = 3;
  localparam int CTRL_WL_LO   = 5;
  localparam int CTRL_FILT_EN = 7;
  localparam int CTRL_DEEMPH  = 8;
  localparam int CTRL_256S    = 9;
  localparam int CTRL_DIV_LO  = 10;
  localparam int CLK_P_LO     = 8;
  localparam int CLK_Q_LO     = 12;
  // Reset values: I2S, 16 bit, divisor 1, J=8 P=1 Q=2
  localparam logic [12:0] CTRL_RST = 13'h0000 | 13'h0010;
  localparam logic [16:0] CLK_RST  = 17'h02008;
  // Serial formats
  localparam logic [1:0] FMT_RJ  = 2'h0;
  localparam logic [1:0] FMT_LJ  = 2'h1;
  localparam logic [1:0] FMT_I2S = 2'h2;
  localparam logic [1:0] FMT_DSP = 2'h3;
  // Rate generation
  localparam logic [7:0]  UPSAMPLE_M1 = 8'h7f;
  localparam logic [21:0] FRAC_SCALE  = 22'h002710;
  localparam logic [21:0] PLL_STEP    = 22'h027100;
  localparam logic [8:0]  BITS_256S   = 9'h100;
  localparam logic [3:0]  DIV_1_5     = 4'h1;
  localparam int          DELAY_TAPS  = 21;
  localparam int          COEF_SHIFT  = 15;
  localparam int          QUANT_LSB   = 12;
  // Default biquad coefficients
  localparam logic signed [15:0] DEF_N0 = 16'sh6be3;
  localparam logic signed [15:0] DEF_N1 = 16'sh9666;
  localparam logic signed [15:0] DEF_N2 = 16'sh675d;
  localparam logic signed [15:0] DEF_D1 = 16'sh7d83;
  localparam logic signed [15:0] DEF_D2 = 16'sh84ee;
endpackage : sad_pkg
`default_nettype wire

/* logic/sad_top.sv */
// Stereo audio serial receiver, rate generation and digital processing
// Behaviour
// - Continuous mode: bit clocks per word-select period equal twice word length.
// - Right-justified: each LSB sits on the last rising edge before ws toggles.
// - Left-justified: MSB on first rising edge after ws edge; ws high is left.
// - I2S: MSB on second rising edge after each ws edge.
// - DSP: ws fall starts frame, left then right, sampled on falling bclk.
// - Rates up to 48 kHz including all standard audio rates.
// - Converter powered: touch clock from audio clocks, oscillator powered down.
// - Modulator rate fixed at 128 times reference rate.
// - Sample rate is reference divided by 1, 1.5, 2, 3, 4, 5 or 6.
// - PLL off: reference is master clock over 128 times Q, Q 2..17.
// - PLL on: reference is master clock times J.D over 2048 times P.
// - PLL accepts 2 to 50 MHz master clock, enable bit in register.
// - De-emphasis only at 32, 44.1 and 48 kHz sample rates.
// - Per-channel bypassable fourth-order IIR as two biquads.
// - Biquad coefficients reset to the shelving boost defaults.
// - Coefficients are 16-bit two's complement.
// - Interpolation adds a group delay of 21 input sample periods.
// - Image rejection and passband ripple targets for interpolation; here images are only held, not filtered.
// - Third-order multibit modulator, ratio 768 down to 128 by rate.
// - Data MSB first, word length 16, 20, 24 or 32.
// - I2S: ws low is left channel, ws high right channel.
// - 256-S: 256 bit clocks per period; 48 kHz with left-justified refused.
// - After reset: I2S slave, converter at reference rate.
`default_nettype none
module sad_top #(
  parameter logic signed [15:0] DEEMPH_B0 = 16'sh55f0,
  parameter logic signed [15:0] DEEMPH_B1 = 16'shd120,
  parameter logic signed [15:0] DEEMPH_A1 = 16'sh58f0
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        bit_clock,
  input  wire logic        word_select,
  input  wire logic        serial_data,
  output var  logic        mod_tick,
  output var  logic        ref_rate_tick,
  output var  logic        converter_output_rate,
  output var  logic        pair_valid,
  output var  logic [3:0]  mod_left,
  output var  logic [3:0]  mod_right,
  output var  logic        ts_clk_from_audio,
  output var  logic        osc_powerdown
);
  typedef enum logic [1:0] {RX_IDLE, RX_LEFT, RX_RIGHT} sad_rx_type;

  function automatic logic [5:0] wl_bits(input logic [1:0] s);
    case (s)
      2'h0:    wl_bits = 6'h10;
      2'h1:    wl_bits = 6'h14;
      2'h2:    wl_bits = 6'h18;
      default: wl_bits = 6'h20;
    endcase
  endfunction : wl_bits

  function automatic logic [9:0] osr_of(input logic [2:0] s);
    case (s)
      3'h0:    osr_of = 10'h080;
      3'h1:    osr_of = 10'h0c0;
      3'h2:    osr_of = 10'h100;
      3'h3:    osr_of = 10'h180;
      3'h4:    osr_of = 10'h200;
      3'h5:    osr_of = 10'h280;
      default: osr_of = 10'h300;
    endcase
  endfunction : osr_of

  function automatic logic signed [15:0] sat16(input logic signed [35:0] v);
    if (v > 36'sh00007fff) sat16 = 16'sh7fff;
    else if (v < -36'sh00008000) sat16 = 16'sh8000;
    else sat16 = v[15:0];
  endfunction : sat16

  function automatic logic signed [15:0] biquad(
      input logic signed [15:0] x, x1, x2, y1, y2, n0, n1, n2, d1, d2);
    logic signed [35:0] acc;
    acc = 36'(n0 * x) + 36'(2 * n1 * x1) + 36'(n2 * x2)
        + 36'(2 * d1 * y1) + 36'(d2 * y2);
    biquad = sat16(acc >>> sad_pkg::COEF_SHIFT);
  endfunction : biquad

  function automatic logic signed [15:0] def_coef(input int i);
    case (i % 5)
      0:       def_coef = sad_pkg::DEF_N0;
      1:       def_coef = sad_pkg::DEF_N1;
      2:       def_coef = sad_pkg::DEF_N2;
      3:       def_coef = sad_pkg::DEF_D1;
      default: def_coef = sad_pkg::DEF_D2;
    endcase
  endfunction : def_coef

  // Register file
  logic [12:0]        ctrl_q;
  logic [16:0]        clk_q;
  logic [13:0]        frac_q;
  logic signed [15:0] coef_q [0:sad_pkg::NUM_COEF-1];
  logic               frame_err_q;
  logic [31:0]        left_q;
  logic [31:0]        right_q;
  logic               wr_pend_q;
  logic               rd_pend_q;
  logic [7:0]         addr_q;
  logic [31:0]        rd_mux;
  logic               cfg_bad;

  wire logic       dac_en  = ctrl_q[sad_pkg::CTRL_DAC_EN];
  wire logic       pll_en  = ctrl_q[sad_pkg::CTRL_PLL_EN];
  wire logic       ref48   = ctrl_q[sad_pkg::CTRL_REF48];
  wire logic [1:0] fmt     = ctrl_q[sad_pkg::CTRL_FMT_LO +: 2];
  wire logic [5:0] wl      = wl_bits(ctrl_q[sad_pkg::CTRL_WL_LO +: 2]);
  wire logic       filt_en = ctrl_q[sad_pkg::CTRL_FILT_EN];
  wire logic       mode256 = ctrl_q[sad_pkg::CTRL_256S];
  wire logic [2:0] div_sel = ctrl_q[sad_pkg::CTRL_DIV_LO +: 3];
  wire logic [6:0] pll_j   = clk_q[6:0];
  wire logic [2:0] pll_pm1 = clk_q[sad_pkg::CLK_P_LO +: 3];
  wire logic [4:0] div_q   = clk_q[sad_pkg::CLK_Q_LO +: 5];
  wire logic       addr_ok = hsel && htrans[1] && hready;

  assign cfg_bad = mode256 && (fmt == sad_pkg::FMT_LJ) && ref48
                   && (div_sel == 3'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      rd_pend_q <= addr_ok && !hwrite;
      if (addr_ok) addr_q <= haddr[7:0];
      // Reads take one wait state so hrdata comes from a flip-flop
      hreadyout <= !(addr_ok && !hwrite);
      if (rd_pend_q) hrdata <= rd_mux;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr_q)
      sad_pkg::OFS_CTRL:   rd_mux = {19'h0, ctrl_q};
      sad_pkg::OFS_CLK:    rd_mux = {15'h0, clk_q};
      sad_pkg::OFS_FRAC:   rd_mux = {18'h0, frac_q};
      sad_pkg::OFS_STATUS: rd_mux = {27'h0, osc_powerdown, ts_clk_from_audio,
                                     pll_en, cfg_bad, frame_err_q};
      sad_pkg::OFS_LEFT:   rd_mux = left_q;
      sad_pkg::OFS_RIGHT:  rd_mux = right_q;
      default: begin
        if (addr_q >= sad_pkg::OFS_COEF && addr_q[1:0] == 2'h0
            && addr_q < 8'(sad_pkg::OFS_COEF + 4 * sad_pkg::NUM_COEF))
          rd_mux = {{16{coef_q[5'((addr_q - sad_pkg::OFS_COEF) >> 2)][15]}},
                    coef_q[5'((addr_q - sad_pkg::OFS_COEF) >> 2)]};
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= sad_pkg::CTRL_RST;
      clk_q  <= sad_pkg::CLK_RST;
      frac_q <= 14'h0000;
    end else if (wr_pend_q) begin
      if (addr_q == sad_pkg::OFS_CTRL) ctrl_q <= hwdata[12:0];
      if (addr_q == sad_pkg::OFS_CLK)  clk_q  <= hwdata[16:0];
      if (addr_q == sad_pkg::OFS_FRAC) frac_q <= hwdata[13:0];
    end
  end

  for (genvar i = 0; i < sad_pkg::NUM_COEF; i++) begin : g_coef
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) coef_q[i] <= def_coef(i);
      else if (wr_pend_q && addr_q == 8'(sad_pkg::OFS_COEF + 4 * i))
        coef_q[i] <= hwdata[15:0];
    end
  end

  // Rate generation: hclk stands in for the master audio clock
  logic [4:0]  qcnt_q;
  logic [21:0] acc_q;
  logic [6:0]  upcnt_q;
  logic [9:0]  rcnt_q;
  wire logic [21:0] k_val = 22'(pll_j) * sad_pkg::FRAC_SCALE + 22'(frac_q);
  wire logic [21:0] k_lim = (22'(pll_pm1) + 22'h000001) * sad_pkg::PLL_STEP;
  wire logic [21:0] acc_n = acc_q + k_val;
  wire logic [9:0]  osr   = osr_of(div_sel);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qcnt_q   <= 5'h00;
      acc_q    <= 22'h000000;
      mod_tick <= 1'b0;
    end else if (pll_en) begin
      acc_q    <= (acc_n >= k_lim) ? acc_n - k_lim : acc_n;
      mod_tick <= acc_n >= k_lim;
    end else begin
      qcnt_q   <= (qcnt_q >= div_q - 5'h1) ? 5'h00 : qcnt_q + 5'h1;
      mod_tick <= qcnt_q >= div_q - 5'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upcnt_q               <= 7'h00;
      rcnt_q                <= 10'h000;
      ref_rate_tick         <= 1'b0;
      converter_output_rate <= 1'b0;
    end else begin
      ref_rate_tick         <= mod_tick && upcnt_q == sad_pkg::UPSAMPLE_M1[6:0];
      converter_output_rate <= mod_tick && rcnt_q == osr - 10'h1;
      if (mod_tick) begin
        upcnt_q <= upcnt_q + 7'h1;
        rcnt_q  <= (rcnt_q >= osr - 10'h1) ? 10'h000 : rcnt_q + 10'h1;
      end
    end
  end

  // Serial receiver
  logic        bclk_prev_q;
  logic        ws_last_q;
  logic [31:0] sh_q;
  logic [5:0]  cnt_q;
  sad_rx_type  rx_q;
  logic [8:0]  bitcnt_q;
  logic        period_seen_q;
  wire logic        dsp      = fmt == sad_pkg::FMT_DSP;
  wire logic        samp     = dsp ? (bclk_prev_q && !bit_clock)
                                   : (!bclk_prev_q && bit_clock);
  wire logic        wschg    = word_select != ws_last_q;
  wire logic [31:0] word_in  = {sh_q[30:0], serial_data};
  wire logic [31:0] word_al  = word_in << (6'h20 - wl);
  wire logic [31:0] rj_word  = sh_q << (6'h20 - wl);
  wire logic        last_bit = cnt_q == wl - 6'h1;
  wire logic        msb_start = wschg && !dsp && fmt != sad_pkg::FMT_RJ;
  wire logic        dsp_start = dsp && ws_last_q && !word_select;
  wire logic [8:0]  exp_bits = mode256 ? sad_pkg::BITS_256S : {2'h0, wl, 1'b0};
  wire logic        chk_now  = samp && wschg && word_select && !dsp;
  logic store_l;
  logic store_r;

  always_comb begin
    store_l = 1'b0;
    store_r = 1'b0;
    if (samp && !cfg_bad) begin
      if (fmt == sad_pkg::FMT_RJ && wschg) begin
        store_l = ws_last_q;
        store_r = !ws_last_q;
      // I2S: the LSB shares its edge with the next word's ws edge
      end else if ((!msb_start || fmt == sad_pkg::FMT_I2S) && !dsp_start
                   && last_bit) begin
        store_l = rx_q == RX_LEFT;
        store_r = rx_q == RX_RIGHT;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bclk_prev_q <= 1'b0;
      ws_last_q   <= 1'b0;
      sh_q        <= 32'h0000_0000;
      cnt_q       <= 6'h00;
      rx_q        <= RX_IDLE;
    end else begin
      bclk_prev_q <= bit_clock;
      if (samp) begin
        ws_last_q <= word_select;
        sh_q      <= word_in;
        if (cfg_bad) begin
          rx_q <= RX_IDLE;
        end else if (dsp_start) begin
          rx_q  <= RX_LEFT;
          cnt_q <= 6'h01;
        end else if (msb_start) begin
          if (fmt == sad_pkg::FMT_I2S) begin
            rx_q  <= word_select ? RX_RIGHT : RX_LEFT;
            cnt_q <= 6'h00;
          end else begin
            rx_q  <= word_select ? RX_LEFT : RX_RIGHT;
            cnt_q <= 6'h01;
          end
        end else begin
          case (rx_q)
            RX_IDLE: cnt_q <= 6'h00;
            RX_LEFT, RX_RIGHT: begin
              cnt_q <= last_bit ? 6'h00 : cnt_q + 6'h1;
              if (last_bit)
                rx_q <= (dsp && rx_q == RX_LEFT) ? RX_RIGHT : RX_IDLE;
            end
            default: rx_q <= RX_IDLE;
          endcase
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left_q     <= 32'h0000_0000;
      right_q    <= 32'h0000_0000;
      pair_valid <= 1'b0;
    end else begin
      if (store_l) left_q <= (fmt == sad_pkg::FMT_RJ) ? rj_word : word_al;
      if (store_r) right_q <= (fmt == sad_pkg::FMT_RJ) ? rj_word : word_al;
      pair_valid <= store_r;
    end
  end

  // Bit-count check; a new error wins over a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bitcnt_q      <= 9'h000;
      period_seen_q <= 1'b0;
      frame_err_q   <= 1'b0;
    end else begin
      if (samp) bitcnt_q <= chk_now ? 9'h001 : bitcnt_q + 9'h1;
      if (chk_now) period_seen_q <= 1'b1;
      if (chk_now && period_seen_q && bitcnt_q != exp_bits)
        frame_err_q <= 1'b1;
      else if (wr_pend_q && addr_q == sad_pkg::OFS_STATUS && hwdata[0])
        frame_err_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ts_clk_from_audio <= 1'b0;
      osc_powerdown     <= 1'b0;
    end else begin
      ts_clk_from_audio <= dac_en;
      osc_powerdown     <= dac_en;
    end
  end

  // De-emphasis exists only for 48, 44.1 and 32 kHz
  wire logic deemph_on = ctrl_q[sad_pkg::CTRL_DEEMPH] && (div_sel == 3'h0
      || (ref48 && div_sel == sad_pkg::DIV_1_5[2:0]));

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic signed [15:0] x_in;
    logic signed [15:0] de_x1_q, de_y1_q, de_out;
    logic signed [15:0] s_q [0:5];
    logic signed [15:0] b1_out, b2_out, proc;
    logic signed [15:0] dly_q [0:sad_pkg::DELAY_TAPS-1];
    logic signed [19:0] e1_q, e2_q, e3_q, v, vc;
    logic signed [35:0] de_acc;
    logic [3:0]         qv;
    assign x_in   = (ch == 0) ? left_q[31:16] : right_q[31:16];
    assign de_acc = 36'(DEEMPH_B0 * x_in) + 36'(DEEMPH_B1 * de_x1_q)
                  + 36'(DEEMPH_A1 * de_y1_q);
    assign de_out = deemph_on ? sat16(de_acc >>> sad_pkg::COEF_SHIFT) : x_in;
    assign b1_out = biquad(de_out, s_q[0], s_q[1], s_q[2], s_q[3],
                           coef_q[ch*10+0], coef_q[ch*10+1], coef_q[ch*10+2],
                           coef_q[ch*10+3], coef_q[ch*10+4]);
    assign b2_out = biquad(b1_out, s_q[2], s_q[3], s_q[4], s_q[5],
                           coef_q[ch*10+5], coef_q[ch*10+6], coef_q[ch*10+7],
                           coef_q[ch*10+8], coef_q[ch*10+9]);
    assign proc   = filt_en ? b2_out : de_out;

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        de_x1_q <= 16'sh0000;
        de_y1_q <= 16'sh0000;
        for (int i = 0; i < 6; i++) s_q[i] <= 16'sh0000;
        for (int i = 0; i < sad_pkg::DELAY_TAPS; i++) dly_q[i] <= 16'sh0000;
      end else if (pair_valid) begin
        de_x1_q <= x_in;
        de_y1_q <= de_out;
        s_q[0]  <= de_out;
        s_q[1]  <= s_q[0];
        s_q[2]  <= b1_out;
        s_q[3]  <= s_q[2];
        s_q[4]  <= b2_out;
        s_q[5]  <= s_q[4];
        dly_q[0] <= proc;
        for (int i = 1; i < sad_pkg::DELAY_TAPS; i++) dly_q[i] <= dly_q[i-1];
      end
    end

    // Error-feedback third-order quantiser; images are only held, not
    // filtered, so the rejection targets rest on the analog stage
    assign v  = 20'(dly_q[sad_pkg::DELAY_TAPS-1]) + 20'(3 * e1_q)
              - 20'(3 * e2_q) + e3_q;
    assign vc = (v > 20'sh07fff) ? 20'sh07fff
              : (v < -20'sh08000) ? -20'sh08000 : v;
    assign qv = vc[15:12];

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        e1_q <= 20'sh00000;
        e2_q <= 20'sh00000;
        e3_q <= 20'sh00000;
      end else if (mod_tick) begin
        e1_q <= v - 20'({{16{qv[3]}}, qv} <<< sad_pkg::QUANT_LSB);
        e2_q <= e1_q;
        e3_q <= e2_q;
      end
    end

    // One driver per output port
    if (ch == 0) begin : g_left
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) mod_left <= 4'h0;
        else if (mod_tick) mod_left <= qv;
      end
    end else begin : g_right
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) mod_right <= 4'h0;
        else if (mod_tick) mod_right <= qv;
      end
    end
  end

  property p_read_wait;
    @(posedge hclk) disable iff (!hresetn)
      (addr_ok && !hwrite) |=> !hreadyout ##1 (hreadyout && hrdata == $past(rd_mux));
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
  property p_qdiv;
    @(posedge hclk) disable iff (!hresetn)
      (!pll_en && $stable(clk_q) && qcnt_q == div_q - 5'h1) |=> mod_tick;
  endproperty
  a_qdiv: assert property (p_qdiv) else $error("integer divider tick missing");
  property p_ref;
    @(posedge hclk) disable iff (!hresetn)
      ref_rate_tick |-> $past(mod_tick)
        && $past(upcnt_q) == sad_pkg::UPSAMPLE_M1[6:0];
  endproperty
  a_ref: assert property (p_ref) else $error("reference tick misplaced");
  property p_rate;
    @(posedge hclk) disable iff (!hresetn)
      (mod_tick && rcnt_q == osr - 10'h1) |=> converter_output_rate;
  endproperty
  a_rate: assert property (p_rate) else $error("sample tick missing");
  sequence s_rstore;
    samp && !cfg_bad && store_r;
  endsequence
  property p_pair;
    @(posedge hclk) disable iff (!hresetn)
      s_rstore |=> pair_valid ##1 !pair_valid;
  endproperty
  a_pair: assert property (p_pair) else $error("pair strobe wrong");
  property p_i2s_left;
    @(posedge hclk) disable iff (!hresetn)
      (samp && wschg && fmt == sad_pkg::FMT_I2S && !word_select && !cfg_bad)
        |=> rx_q == RX_LEFT && cnt_q == 6'h00;
  endproperty
  a_i2s_left: assert property (p_i2s_left) else $error("I2S left start");
  property p_rj;
    @(posedge hclk) disable iff (!hresetn)
      (samp && wschg && fmt == sad_pkg::FMT_RJ && ws_last_q && !cfg_bad)
        |=> left_q == $past(rj_word);
  endproperty
  a_rj: assert property (p_rj) else $error("right-justified capture");
  property p_ferr;
    @(posedge hclk) disable iff (!hresetn)
      (chk_now && period_seen_q && bitcnt_q != exp_bits) |=> frame_err_q;
  endproperty
  a_ferr: assert property (p_ferr) else $error("bit count error lost");
  property p_ts;
    @(posedge hclk) disable iff (!hresetn)
      dac_en [*2] |-> ts_clk_from_audio && osc_powerdown;
  endproperty
  a_ts: assert property (p_ts) else $error("touch clock source");
  property p_refuse;
    @(posedge hclk) disable iff (!hresetn)
      cfg_bad |-> !store_l && !store_r;
  endproperty
  a_refuse: assert property (p_refuse) else $error("unsupported taken");
endmodule : sad_top
`default_nettype wire

/* verif/sad_src.sv */
// Serial audio source that plays stereo frames into the input path
`default_nettype none
module sad_src (
  input  wire logic hclk,
  output var  logic bit_clock,
  output var  logic word_select,
  output var  logic serial_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    bit_clock = 1'b0;
    word_select = 1'b0;
    serial_data = 1'b0;
  end
  // Bit clock rests low between frames; tail slot makes ws toggle once more in every format but I2S
  task automatic send(input logic [1:0] f, input int w,
                      input logic [31:0] l, input logic [31:0] r,
                      input bit tail);
    int   k;
    logic s;
    logic b;
    for (int i = 0; i < 2 * w + int'(tail); i++) begin
      k = i % (2 * w);
      if (i == 2 * w) b = ~serial_data;
      else b = (i < w) ? l[w - 1 - i] : r[2 * w - 1 - i];
      case (f)
        2'h2:    s = ((k + 1) % (2 * w)) >= w;
        2'h3:    s = (k == 2 * w - 1);
        default: s = (k < w);
      endcase
      @(posedge hclk);
      bit_clock <= 1'b0;
      if (f != 2'h3) begin
        word_select <= s;
        serial_data <= b;
      end
      repeat (4) @(posedge hclk);
      bit_clock <= 1'b1;
      if (f == 2'h3) begin
        word_select <= s;
        serial_data <= b;
      end
      repeat (3) @(posedge hclk);
    end
    @(posedge hclk);
    bit_clock <= 1'b0;
    // Released line flips so a stale bit never passes for data
    repeat (4) @(posedge hclk);
    serial_data <= ~serial_data;
  endtask : send
endmodule : sad_src
`default_nettype wire

/* verif/stereo_audio_dac_input_path_tb_top.sv */
// Self-checking bench for the stereo audio input path
`default_nettype none
module stereo_audio_dac_input_path_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd, lw, rw;
  logic        hreadyout, hresp, pair_valid, mod_tick, ref_tick, ts_clk;
  logic        osc_pd, bclk, ws, sdata, cor;
  logic [1:0]  wl;
  int          miscompares = 0;
  int          comparisons = 0;
  int          seed = 77;
  int          pv_cnt = 0;
  int          mcnt = 0;
  int          w, p0;
  bit          seen = 0;
  always #50 hclk = ~hclk;
  sad_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .bit_clock(bclk), .word_select(ws), .serial_data(sdata),
    .mod_tick(mod_tick), .ref_rate_tick(ref_tick), .converter_output_rate(cor),
    .pair_valid(pair_valid), .mod_left(), .mod_right(),
    .ts_clk_from_audio(ts_clk), .osc_powerdown(osc_pd));
  sad_src src_u (.hclk(hclk), .bit_clock(bclk), .word_select(ws),
    .serial_data(sdata));
  function automatic logic [31:0] coef(input int i);
    int t[5] = '{27619, -27034, 26461, 32131, -31506};
    return 32'(t[i]);
  endfunction : coef
  function automatic logic [31:0] exp_word(input logic [31:0] v, input int n);
    return v << (32 - n);
  endfunction : exp_word
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin
      miscompares++;
      print_verdict();
    end
  endtask : wait_rdy
  // Select stays up between transfers; idle htrans marks the gaps
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  always @(posedge hclk) begin
    if (pair_valid === 1'b1) pv_cnt++;
    // Divisor stays 1, so sample and reference ticks coincide
    if (ref_tick === 1'b1 || cor === 1'b1)
      chk({31'h0, cor}, {31'h0, ref_tick});
    if (ref_tick === 1'b1) begin
      if (seen) chk(32'(mcnt), 32'd128);
      seen = 1;
      mcnt = int'(mod_tick === 1'b1);
    end else if (mod_tick === 1'b1) mcnt++;
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({31'h0, ts_clk}, 32'h0);
    bus(0, sad_pkg::OFS_CTRL, 0);
    chk(rd, 32'h10);
    bus(0, 8'h20, 0);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    bus(0, sad_pkg::OFS_CLK, 0);
    chk(rd, 32'h2008);
    for (int i = 0; i < 5; i++) begin
      bus(0, sad_pkg::OFS_COEF + 8'(4 * i), 0);
      chk(rd, coef(i));
    end
    bus(1, sad_pkg::OFS_COEF, 32'h12348000);
    bus(0, sad_pkg::OFS_COEF, 0);
    chk(rd, 32'hffff8000);
    for (int f = 0; f < 4; f++) begin
      wl = 2'($random(seed));
      w = (wl == 2'h3) ? 32 : 16 + 4 * int'(wl);
      bus(1, sad_pkg::OFS_CTRL, 32'(f * 8 + int'(wl) * 32 + 1));
      // Two lead-in frames so every format sees a full period before checks
      repeat (2) src_u.send(2'(f), w, $random(seed), $random(seed), 0);
      chk({31'h0, osc_pd}, 32'h1);
      bus(1, sad_pkg::OFS_STATUS, 32'h1);
      lw = $random(seed);
      rw = $random(seed);
      p0 = pv_cnt;
      src_u.send(2'(f), w, lw, rw, 1);
      chk(32'(pv_cnt != p0), 32'h1);
      bus(0, sad_pkg::OFS_LEFT, 0);
      chk(rd, exp_word(lw, w));
      bus(0, sad_pkg::OFS_RIGHT, 0);
      chk(rd, exp_word(rw, w));
      bus(0, sad_pkg::OFS_STATUS, 0);
      chk(rd & 32'h1, 32'h0);
      $display("format %0d width %0d done", f, w);
    end
    bus(1, sad_pkg::OFS_CTRL, 32'h11);
    src_u.send(2'h2, 16, 0, 0, 0);
    src_u.send(2'h2, 20, lw, rw, 1);
    bus(0, sad_pkg::OFS_STATUS, 0);
    chk(rd & 32'h1, 32'h1);
    bus(1, sad_pkg::OFS_STATUS, 32'h1);
    bus(0, sad_pkg::OFS_STATUS, 0);
    chk(rd & 32'h1, 32'h0);
    bus(1, sad_pkg::OFS_CTRL, 32'h20d);
    bus(0, sad_pkg::OFS_STATUS, 0);
    chk(rd & 32'h1e, 32'h1a);
    $display("length and refusal cases done");
    print_verdict();
  end
endmodule : stereo_audio_dac_input_path_tb_top
`default_nettype wire
